// *** core/can_trx_mode_defines.vh ***
`ifndef CAN_TRX_MODE_DEFINES_VH
`define CAN_TRX_MODE_DEFINES_VH
// Register addresses
`define ADDR_DEVICE_MODE_CONTROL 8'h01
`define ADDR_DEVICE_MODE_STATUS  8'h03
`define ADDR_TRANSCEIVER_CONTROL 8'h20
`define ADDR_TRANSCEIVER_STATUS  8'h22
`define ADDR_TRX_EVENT_ENABLE    8'h23
// Reset values
`define RST_DEVICE_MODE   3'h4
`define RST_TRX_SELECT    2'h1
`define RST_BUS_WAKE_EN   1'h0
// Device mode codes
`define DMODE_SLEEP       3'h1
`define DMODE_STANDBY     3'h4
`define DMODE_NORMAL      3'h7
// Transceiver selection codes
`define TSEL_STANDBY      2'h0
`define TSEL_NORMAL_UV    2'h1
`define TSEL_NORMAL_NOUV  2'h2
`define TSEL_SILENT       2'h3
// Field positions
`define BIT_SLEEP_CAUSE   7
`define BIT_OT_PREWARN    6
`define BIT_NORMAL_PEND   5
`define BIT_TX_READY      7
`define BIT_BUS_SILENT    3
`define BIT_VCC_UV        1
`define BIT_BUS_WAKE_EN   0
// Timing in ns and derived cycles at 8 ns
`define CLK_PERIOD_NS     8
`define T_FILTER_NS       1000
`define T_SUP_UV_NS       10000
`define T_SILENCE_NS      1000000
`define FILTER_CYCLES     ((`T_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUP_UV_CYCLES     (`T_SUP_UV_NS / `CLK_PERIOD_NS)
`define SILENCE_CYCLES    (`T_SILENCE_NS / `CLK_PERIOD_NS)
`define CNT_W             20
`endif

// *** core/can_trx_mode_controller.v ***
// Operation
// [R1] Device mode field: 001 Sleep, 100 Standby, 111 Normal.
// [R2] Sleep cause bit clears on host-commanded sleep, sets on undervoltage sleep.
// [R3] Prewarning bit follows die temperature against prewarning threshold.
// [R4] Normal-pending bit high after power-up until Normal first entered.
// [R5] Device Standby or Sleep keeps transceiver in Standby or Biased Standby.
// [R6] Selection field never picks Biased Standby directly.
// [R7] Bus activity in Standby moves to Biased Standby, bus biased mid-supply; code needs a full wake pattern when bus wake is enabled.
// [R8] Biased Standby returns to Standby after bus silence timeout.
// [R9] Power Off, Overtemp or battery undervoltage forces TRX Off.
// [R10] Leave Off for Standby when battery recovers and device mode allows; code leaves Off on battery recovery whatever the device mode.
// [R11] In Off bus pins float and receive output held high.
// [R12] Enabled wake pattern of two filtered dominant phases drives receive low.
// [R13] Active states go Biased Standby on Standby/Sleep mode, Standby if silent.
// [R14] Active states go Biased Standby when Normal and selection Standby.
// [R15] Selection 01 with VCC undervoltage in Normal states goes Biased Standby.
// [R16] Standby enters Biased Standby in Normal, selection 01, VCC below shutdown.
// [R17] Bus wake-up event in Standby enters Biased Standby.
// [R18] Silent receives, transmitter off, bus recessive, biasing kept.
// [R19] Clamping failure moves Normal to Silent; stay while undervoltage or clamping.
// [R20] Normal entered only with Normal mode, selection 01/10, no UV, no clamp.
// [R21] Reduced Normal returns to Normal after VCC good for filter time.
// [R22] Transmit input low blocks Normal; stay Silent until it goes high.
// [R23] Normal drives transmit level to bus, received level to receive output.
// [R24] Selection: 00 Standby, 01 Normal UV on, 10 Normal UV off, 11 Silent.
// [R25] Reduced Normal disables transmitter while keeping other Normal functions.
// [R26] Transmitter-ready status bit reads one when transmitter can send.
// [R27] Reserved bits read zero and ignore writes.
// [R28] Undefined device mode write leaves mode unchanged.
`include "can_trx_mode_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module can_trx_mode_controller (
    input  wire       clock_in,
    input  wire       reset_in,
    input  wire       reg_write_in,
    input  wire       reg_read_in,
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    output reg  [7:0] reg_rdata_out,
    input  wire       dev_power_off_in,
    input  wire       dev_overtemp_in,
    input  wire       uv_sleep_in,
    input  wire       ot_prewarn_in,
    input  wire       vs_uv_set_in,
    input  wire       vs_uv_release_in,
    input  wire       vcc_uv_in,
    input  wire       vcc_tx_sd_in,
    input  wire       rxd_clamp_in,
    input  wire       bus_dominant_in,
    input  wire       txd_in,
    output reg        rxd_out,
    output reg        tx_drive_out,
    output reg        tx_enable_out,
    output reg        bias_mid_out,
    output reg        bus_hiz_out,
    output reg        bus_wake_out,
    output reg  [5:0] trx_state_out,
    output reg  [2:0] device_mode_out
);

////////////////////////////////////////////////////////////////////////////////
localparam [5:0] ST_OFF     = 6'h01;
localparam [5:0] ST_STBY    = 6'h02;
localparam [5:0] ST_BIASED  = 6'h04;
localparam [5:0] ST_SILENT  = 6'h08;
localparam [5:0] ST_NORMAL  = 6'h10;
localparam [5:0] ST_REDUCED = 6'h20;

localparam [3:0] WU_IDLE = 4'h1;
localparam [3:0] WU_DOM1 = 4'h2;
localparam [3:0] WU_REC  = 4'h4;
localparam [3:0] WU_DOM2 = 4'h8;

localparam integer FILTER_I  = `FILTER_CYCLES;
localparam integer SUP_UV_I  = `SUP_UV_CYCLES;
localparam integer SILENCE_I = `SILENCE_CYCLES;

localparam [`CNT_W-1:0] FILTER_N  = FILTER_I[`CNT_W-1:0];
localparam [`CNT_W-1:0] SUP_UV_N  = SUP_UV_I[`CNT_W-1:0];
localparam [`CNT_W-1:0] SILENCE_N = SILENCE_I[`CNT_W-1:0];

reg [2:0]        device_mode;
reg [1:0]        trx_select;
reg              bus_wake_enable;
reg              sleep_cause_status;
reg              normal_mode_pending;
reg [5:0]        state;
reg [5:0]        next_state;
reg [`CNT_W-1:0] silence_count;
reg              silence_timeout;
reg [`CNT_W-1:0] vcc_good_count;
reg [`CNT_W-1:0] vcc_low_count;
reg [`CNT_W-1:0] phase_count;
reg [3:0]        wake_phase;
reg              bus_wake_pattern;
reg              bus_prev;
reg              txd_seen_high;

wire dev_normal  = (device_mode == `DMODE_NORMAL);
wire dev_low     = (device_mode == `DMODE_STANDBY) | (device_mode == `DMODE_SLEEP);
wire sel_normal  = (trx_select == `TSEL_NORMAL_UV) | (trx_select == `TSEL_NORMAL_NOUV);
wire uv_active   = (trx_select == `TSEL_NORMAL_UV) & vcc_uv_in;
wire bus_active  = bus_dominant_in != bus_prev;
wire off_cause   = dev_power_off_in | dev_overtemp_in | vs_uv_set_in;
wire vcc_low_ok  = vcc_low_count >= SUP_UV_N;
wire vcc_good_ok = vcc_good_count >= SUP_UV_N;
wire tx_capable  = (state == ST_NORMAL) & ~vcc_tx_sd_in;

////////////////////////////////////////////////////////////////////////////////
// Register writes
always @(posedge clock_in) begin
    if (reset_in) begin
        device_mode     <= `RST_DEVICE_MODE;
        trx_select      <= `RST_TRX_SELECT;
        bus_wake_enable <= `RST_BUS_WAKE_EN;
    end else if (uv_sleep_in) begin
        device_mode     <= `DMODE_SLEEP;
        bus_wake_enable <= 1'b1;
    end else if (reg_write_in) begin
        case (reg_addr_in)
            `ADDR_DEVICE_MODE_CONTROL: begin
                if ((reg_wdata_in[2:0] == `DMODE_SLEEP) ||
                    (reg_wdata_in[2:0] == `DMODE_STANDBY) ||
                    (reg_wdata_in[2:0] == `DMODE_NORMAL)) begin // R1 R28
                    device_mode <= reg_wdata_in[2:0];
                end
            end
            `ADDR_TRANSCEIVER_CONTROL: begin
                trx_select <= reg_wdata_in[1:0]; // R24
            end
            `ADDR_TRX_EVENT_ENABLE: begin
                bus_wake_enable <= reg_wdata_in[`BIT_BUS_WAKE_EN];
            end
            default: begin
                trx_select <= trx_select;
            end
        endcase
    end
end

// Mode transition status
always @(posedge clock_in) begin
    if (reset_in) begin
        sleep_cause_status  <= 1'b0;
        normal_mode_pending <= 1'b1;
    end else begin
        if (uv_sleep_in) begin
            sleep_cause_status <= 1'b1; // R2
        end else if (reg_write_in && (reg_addr_in == `ADDR_DEVICE_MODE_CONTROL) &&
                     (reg_wdata_in[2:0] == `DMODE_SLEEP)) begin
            sleep_cause_status <= 1'b0; // R2
        end
        if (dev_normal) begin
            normal_mode_pending <= 1'b0; // R4
        end
    end
end

// Register reads, reserved bits zero
always @(posedge clock_in) begin
    if (reset_in) begin
        reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
        reg_rdata_out <= 8'h00; // R27
        case (reg_addr_in)
            `ADDR_DEVICE_MODE_CONTROL: reg_rdata_out[2:0] <= device_mode;
            `ADDR_DEVICE_MODE_STATUS: begin
                reg_rdata_out[`BIT_SLEEP_CAUSE] <= sleep_cause_status;
                reg_rdata_out[`BIT_OT_PREWARN]  <= ot_prewarn_in; // R3
                reg_rdata_out[`BIT_NORMAL_PEND] <= normal_mode_pending;
            end
            `ADDR_TRANSCEIVER_CONTROL: reg_rdata_out[1:0] <= trx_select;
            `ADDR_TRANSCEIVER_STATUS: begin
                reg_rdata_out[`BIT_TX_READY]   <= tx_capable; // R26
                reg_rdata_out[`BIT_BUS_SILENT] <= silence_timeout;
                reg_rdata_out[`BIT_VCC_UV]     <= vcc_uv_in;
            end
            `ADDR_TRX_EVENT_ENABLE: reg_rdata_out[`BIT_BUS_WAKE_EN] <= bus_wake_enable;
            default: reg_rdata_out <= 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus silence and supply filter timers
always @(posedge clock_in) begin
    if (reset_in) begin
        bus_prev        <= 1'b0;
        silence_count   <= {`CNT_W{1'b0}};
        silence_timeout <= 1'b1;
        vcc_good_count  <= {`CNT_W{1'b0}};
        vcc_low_count   <= {`CNT_W{1'b0}};
        txd_seen_high   <= 1'b0;
    end else begin
        bus_prev <= bus_dominant_in;
        if (bus_active || bus_dominant_in) begin
            silence_count   <= {`CNT_W{1'b0}};
            silence_timeout <= 1'b0;
        end else if (silence_count < SILENCE_N) begin
            silence_count <= silence_count + 1'b1;
        end else begin
            silence_timeout <= 1'b1; // R8
        end
        if (vcc_tx_sd_in) begin
            vcc_good_count <= {`CNT_W{1'b0}};
        end else if (!vcc_good_ok) begin
            vcc_good_count <= vcc_good_count + 1'b1;
        end
        if (!vcc_tx_sd_in) begin
            vcc_low_count <= {`CNT_W{1'b0}};
        end else if (!vcc_low_ok) begin
            vcc_low_count <= vcc_low_count + 1'b1;
        end
        if (!(dev_normal && sel_normal)) begin
            txd_seen_high <= 1'b0;
        end else if (txd_in) begin
            txd_seen_high <= 1'b1; // R22
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Wake pattern detector
always @(posedge clock_in) begin
    if (reset_in) begin
        wake_phase       <= WU_IDLE;
        phase_count      <= {`CNT_W{1'b0}};
        bus_wake_pattern <= 1'b0;
    end else if (state != ST_STBY || !bus_wake_enable) begin
        wake_phase  <= WU_IDLE;
        phase_count <= {`CNT_W{1'b0}};
        if (state != ST_BIASED) begin
            bus_wake_pattern <= 1'b0;
        end
    end else begin
        phase_count <= (phase_count < FILTER_N) ? phase_count + 1'b1 : phase_count;
        case (wake_phase)
            WU_IDLE: begin
                phase_count <= {`CNT_W{1'b0}};
                if (bus_dominant_in) begin
                    wake_phase <= WU_DOM1;
                end
            end
            WU_DOM1: begin
                if (!bus_dominant_in) begin
                    phase_count <= {`CNT_W{1'b0}};
                    wake_phase  <= (phase_count >= FILTER_N) ? WU_REC : WU_IDLE;
                end
            end
            WU_REC: begin
                if (bus_dominant_in) begin
                    phase_count <= {`CNT_W{1'b0}};
                    wake_phase  <= (phase_count >= FILTER_N) ? WU_DOM2 : WU_DOM1;
                end
            end
            WU_DOM2: begin
                if (phase_count >= FILTER_N) begin
                    bus_wake_pattern <= 1'b1; // R12
                    wake_phase       <= WU_IDLE;
                end else if (!bus_dominant_in) begin
                    phase_count <= {`CNT_W{1'b0}};
                    wake_phase  <= WU_REC;
                end
            end
            default: wake_phase <= WU_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Transceiver state machine
always @* begin
    next_state = state;
    case (state)
        ST_OFF: begin
            if (!off_cause && vs_uv_release_in) begin
                next_state = ST_STBY; // R10
            end
        end
        ST_STBY: begin
            if (bus_wake_pattern) begin
                next_state = ST_BIASED; // R17
            end else if (bus_active && !bus_wake_enable) begin
                // With wake detection on, only a full pattern biases the bus
                next_state = ST_BIASED; // R7
            end else if (dev_normal && trx_select == `TSEL_NORMAL_UV && vcc_tx_sd_in) begin
                next_state = ST_BIASED; // R16
            end else if (dev_normal && trx_select == `TSEL_SILENT) begin
                next_state = ST_SILENT;
            end else if (dev_normal && sel_normal && !uv_active) begin
                next_state = (rxd_clamp_in || !txd_seen_high) ? ST_SILENT : ST_NORMAL;
            end
        end
        ST_BIASED: begin
            if (silence_timeout) begin
                next_state = ST_STBY; // R8
            end else if (dev_normal && trx_select == `TSEL_SILENT) begin
                next_state = ST_SILENT;
            end else if (dev_normal && sel_normal && !uv_active) begin
                next_state = (rxd_clamp_in || !txd_seen_high) ? ST_SILENT : ST_NORMAL; // R20
            end
        end
        ST_SILENT, ST_NORMAL, ST_REDUCED: begin
            if (dev_low || (dev_normal && trx_select == `TSEL_STANDBY)) begin
                next_state = silence_timeout ? ST_STBY : ST_BIASED; // R5 R13 R14
            end else if (uv_active && state != ST_SILENT) begin
                next_state = silence_timeout ? ST_STBY : ST_BIASED; // R15
            end else if (trx_select == `TSEL_SILENT) begin
                next_state = ST_SILENT;
            end else if (rxd_clamp_in || uv_active || !txd_seen_high) begin
                next_state = ST_SILENT; // R19 R22
            end else if (state == ST_SILENT) begin
                next_state = ST_NORMAL; // R20
            end else if (state == ST_NORMAL && vcc_low_ok) begin
                next_state = ST_REDUCED;
            end else if (state == ST_REDUCED && vcc_good_ok) begin
                next_state = ST_NORMAL; // R21
            end
        end
        default: next_state = ST_OFF;
    endcase
    if (off_cause) begin
        next_state = ST_OFF; // R9
    end
end

// State register and pin drive, selection never yields Biased Standby alone
always @(posedge clock_in) begin
    if (reset_in) begin
        state           <= ST_OFF;
        rxd_out         <= 1'b1;
        tx_drive_out    <= 1'b0;
        tx_enable_out   <= 1'b0;
        bias_mid_out    <= 1'b0;
        bus_hiz_out     <= 1'b1;
        bus_wake_out    <= 1'b0;
        trx_state_out   <= ST_OFF;
        device_mode_out <= `RST_DEVICE_MODE;
    end else begin
        state           <= next_state; // R6
        trx_state_out   <= next_state;
        device_mode_out <= device_mode;
        bus_hiz_out     <= (next_state == ST_OFF); // R11
        bias_mid_out    <= (next_state != ST_OFF) && (next_state != ST_STBY); // R7 R18
        tx_enable_out   <= (next_state == ST_NORMAL); // R25 R18
        tx_drive_out    <= (next_state == ST_NORMAL) & ~txd_in; // R23
        bus_wake_out    <= bus_wake_pattern;
        case (next_state)
            ST_SILENT, ST_NORMAL, ST_REDUCED: rxd_out <= ~bus_dominant_in; // R18 R23
            ST_STBY, ST_BIASED:               rxd_out <= ~bus_wake_pattern; // R12
            default:                          rxd_out <= 1'b1; // R11
        endcase
    end
end

endmodule // can_trx_mode_controller
`default_nettype wire

// *** testbench/can_trx_mode_controller_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module can_trx_mode_controller_asserts (
    input wire logic       clock_in,
    input wire logic       reset_in,
    input wire logic       reg_read_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       dev_power_off_in,
    input wire logic       rxd_clamp_in,
    input wire logic       bus_dominant_in,
    input wire logic       txd_in,
    input wire logic       rxd_out,
    input wire logic       tx_drive_out,
    input wire logic       tx_enable_out,
    input wire logic       bias_mid_out,
    input wire logic       bus_hiz_out,
    input wire logic [5:0] trx_state_out,
    input wire logic [2:0] device_mode_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////////////
    a_off_pins: assert property (trx_state_out == 6'h01 |-> bus_hiz_out && rxd_out)
        else $error("bus not released in off state");
    a_bias_active: assert property (trx_state_out inside {6'h04, 6'h08, 6'h10, 6'h20}
        |-> bias_mid_out && !bus_hiz_out)
        else $error("bias missing in biased state");
    a_low_power: assert property ((device_mode_out != 3'h7) [*3]
        |-> trx_state_out inside {6'h01, 6'h02, 6'h04})
        else $error("active state outside device normal");
    a_tx_normal: assert property (tx_enable_out |-> trx_state_out == 6'h10)
        else $error("transmitter on outside normal");
    a_drive_txd: assert property (trx_state_out[4] && $past(trx_state_out[4])
        |-> tx_drive_out == !$past(txd_in) && rxd_out == !$past(bus_dominant_in))
        else $error("normal path does not follow pins");
    a_normal_entry: assert property ($rose(trx_state_out[4]) && $past(trx_state_out[3])
        |-> txd_in || $past(txd_in))
        else $error("normal entered with transmit input low");
    a_clamp_exit: assert property (rxd_clamp_in && trx_state_out == 6'h10
        |-> ##[1:2] trx_state_out == 6'h08)
        else $error("clamping did not force silent");
    a_power_off: assert property (dev_power_off_in |-> ##[1:2] trx_state_out == 6'h01)
        else $error("power off did not force off state");
    a_status_zero: assert property ($past(reg_read_in) && $past(reg_addr_in) == 8'h03
        |-> reg_rdata_out[4:0] == 5'h00)
        else $error("reserved status bits not zero");
    c_normal: cover property (trx_state_out == 6'h10);
    c_silent: cover property (trx_state_out == 6'h08);
    c_reduced: cover property (trx_state_out == 6'h20);
endmodule // can_trx_mode_controller_asserts
`default_nettype wire

// *** testbench/can_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module can_ctrl_model (
    input  wire logic clock_in,
    input  wire logic stuck_low_in,
    input  wire logic send_in,
    output var logic  txd_out
);
    logic [1:0] phase = 2'h0;
    initial txd_out = 1'b1;
    // Idle recessive, toggles while sending, stuck fault on command
    always @(posedge clock_in) begin
        phase <= phase + 2'h1;
        txd_out <= stuck_low_in ? 1'b0 : (!send_in | phase[1]);
    end
endmodule // can_ctrl_model
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       clock_in = 1'b0, reset_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    logic       dev_power_off_in = 1'b0, dev_overtemp_in = 1'b0, uv_sleep_in = 1'b0;
    logic       ot_prewarn_in = 1'b0, vs_uv_set_in = 1'b0, vs_uv_release_in = 1'b1;
    logic       vcc_uv_in = 1'b0, vcc_tx_sd_in = 1'b0, rxd_clamp_in = 1'b0;
    logic       node_dom = 1'b0, stuck_low = 1'b0, send = 1'b0;
    wire        txd_in, bus_dominant_in, rxd_out, tx_drive_out, tx_enable_out;
    wire        bias_mid_out, bus_hiz_out, bus_wake_out;
    wire [7:0]  reg_rdata_out;
    wire [5:0]  trx_state_out;
    wire [2:0]  device_mode_out;
    int         errors = 0, checks_done = 0, cycles = 0;
    assign bus_dominant_in = node_dom | (tx_drive_out & tx_enable_out);
    always #4 clock_in = ~clock_in;
    can_ctrl_model ctrl (.clock_in(clock_in), .stuck_low_in(stuck_low), .send_in(send),
        .txd_out(txd_in));
    can_trx_mode_controller dut (.clock_in(clock_in), .reset_in(reset_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .dev_power_off_in(dev_power_off_in), .dev_overtemp_in(dev_overtemp_in),
        .uv_sleep_in(uv_sleep_in), .ot_prewarn_in(ot_prewarn_in), .vs_uv_set_in(vs_uv_set_in),
        .vs_uv_release_in(vs_uv_release_in), .vcc_uv_in(vcc_uv_in),
        .vcc_tx_sd_in(vcc_tx_sd_in), .rxd_clamp_in(rxd_clamp_in),
        .bus_dominant_in(bus_dominant_in), .txd_in(txd_in), .rxd_out(rxd_out),
        .tx_drive_out(tx_drive_out), .tx_enable_out(tx_enable_out), .bias_mid_out(bias_mid_out),
        .bus_hiz_out(bus_hiz_out), .bus_wake_out(bus_wake_out), .trx_state_out(trx_state_out),
        .device_mode_out(device_mode_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            $display("[ERR] run time expected end seen limit");
            end_of_test();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clock_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        #1;
        check($sformatf("register %h", a), exp, reg_rdata_out & m);
    endtask
    task automatic wait_st(input logic [5:0] exp);
        int n;
        n = 0;
        while (trx_state_out !== exp && n < 3000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        check("trx_state", {2'h0, exp}, {2'h0, trx_state_out});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        rd(8'h01, 8'hFF, 8'h04);
        rd(8'h03, 8'hFF, 8'h20);
        rd(8'h20, 8'h03, 8'h01);
        rd(8'h7F, 8'hFF, 8'h00);
        wait_st(6'h02);
        @(posedge clock_in) node_dom <= 1'b1;
        @(posedge clock_in) node_dom <= 1'b0;
        wait_st(6'h04);
        $display("power-up test done");
    endtask
    task automatic t_normal();
        wr(8'h01, 8'h07);
        wait_st(6'h10);
        rd(8'h03, 8'h20, 8'h00);
        rd(8'h22, 8'h80, 8'h80);
        @(posedge clock_in) send <= 1'b1;
        repeat (40) @(posedge clock_in);
        send <= 1'b0;
        wr(8'h01, 8'h02);
        repeat (3) @(posedge clock_in);
        check("device_mode", 8'h07, {5'h00, device_mode_out});
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'hFF, 8'h07);
        $display("normal test done");
    endtask
    task automatic t_selection();
        wr(8'h20, 8'h03);
        wait_st(6'h08);
        check("tx_enable", 8'h00, {7'h00, tx_enable_out});
        wr(8'h20, 8'h00);
        wait_st(6'h04);
        wr(8'h20, 8'h01);
        wait_st(6'h10);
        $display("selection test done");
    endtask
    task automatic t_faults();
        @(posedge clock_in) rxd_clamp_in <= 1'b1;
        wait_st(6'h08);
        @(posedge clock_in) rxd_clamp_in <= 1'b0;
        wait_st(6'h10);
        @(posedge clock_in) vcc_uv_in <= 1'b1;
        wait_st(6'h04);
        @(posedge clock_in) vcc_uv_in <= 1'b0;
        wait_st(6'h10);
        wr(8'h20, 8'h00);
        wait_st(6'h04);
        @(posedge clock_in) stuck_low <= 1'b1;
        wr(8'h20, 8'h01);
        wait_st(6'h08);
        @(posedge clock_in) stuck_low <= 1'b0;
        wait_st(6'h10);
        $display("fault test done");
    endtask
    task automatic t_reduced();
        wr(8'h20, 8'h02);
        @(posedge clock_in) vcc_tx_sd_in <= 1'b1;
        wait_st(6'h20);
        rd(8'h22, 8'h80, 8'h00);
        @(posedge clock_in) vcc_tx_sd_in <= 1'b0;
        repeat (100) @(posedge clock_in);
        check("trx_state", 8'h20, {2'h0, trx_state_out});
        wait_st(6'h10);
        $display("reduced test done");
    endtask
    task automatic t_sleep();
        @(posedge clock_in) ot_prewarn_in <= 1'b1;
        rd(8'h03, 8'h40, 8'h40);
        @(posedge clock_in) ot_prewarn_in <= 1'b0;
        rd(8'h03, 8'h40, 8'h00);
        wr(8'h01, 8'h01);
        wait_st(6'h04);
        rd(8'h03, 8'h80, 8'h00);
        wr(8'h01, 8'h07);
        wait_st(6'h10);
        @(posedge clock_in) uv_sleep_in <= 1'b1;
        @(posedge clock_in) uv_sleep_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        check("device_mode", 8'h01, {5'h00, device_mode_out});
        rd(8'h03, 8'h80, 8'h80);
        $display("sleep test done");
    endtask
    task automatic t_off();
        @(posedge clock_in) dev_overtemp_in <= 1'b1;
        wait_st(6'h01);
        @(posedge clock_in) dev_overtemp_in <= 1'b0;
        wait_st(6'h02);
        @(posedge clock_in) vs_uv_set_in <= 1'b1;
        vs_uv_release_in <= 1'b0;
        wait_st(6'h01);
        @(posedge clock_in) vs_uv_set_in <= 1'b0;
        vs_uv_release_in <= 1'b1;
        wait_st(6'h02);
        @(posedge clock_in) dev_power_off_in <= 1'b1;
        wait_st(6'h01);
        @(posedge clock_in) dev_power_off_in <= 1'b0;
        wait_st(6'h02);
        $display("off test done");
    endtask
    task automatic t_wake();
        @(posedge clock_in) node_dom <= 1'b1;
        repeat (130) @(posedge clock_in);
        node_dom <= 1'b0;
        repeat (130) @(posedge clock_in);
        #1;
        check("trx_state", 8'h02, {2'h0, trx_state_out});
        check("rxd", 8'h01, {7'h00, rxd_out});
        @(posedge clock_in) node_dom <= 1'b1;
        wait_st(6'h04);
        check("bus_wake", 8'h01, {7'h00, bus_wake_out});
        check("rxd", 8'h00, {7'h00, rxd_out});
        @(posedge clock_in) node_dom <= 1'b0;
        $display("wake test done");
    endtask
    initial begin
        repeat (4) @(posedge clock_in);
        reset_in <= 1'b0;
        t_power_up();
        t_normal();
        t_selection();
        t_faults();
        t_reduced();
        t_sleep();
        t_off();
        t_wake();
        end_of_test();
    end
endmodule // testbench
bind can_trx_mode_controller can_trx_mode_controller_asserts chk (.clock_in(clock_in),
    .reset_in(reset_in), .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in),
    .reg_rdata_out(reg_rdata_out), .dev_power_off_in(dev_power_off_in),
    .rxd_clamp_in(rxd_clamp_in), .bus_dominant_in(bus_dominant_in), .txd_in(txd_in),
    .rxd_out(rxd_out), .tx_drive_out(tx_drive_out), .tx_enable_out(tx_enable_out),
    .bias_mid_out(bias_mid_out), .bus_hiz_out(bus_hiz_out), .trx_state_out(trx_state_out),
    .device_mode_out(device_mode_out));
`default_nettype wire
